// [hdl/ssc_pkg.sv]
// Purpose: Shared constants for the sample sync, clock and pin configuration block
// Assumes: 16-bit registers at 8-bit word addresses on the serial register port
// Notes:   Fields are bit positions inside their registers
package ssc_pkg;
    localparam int          REG_AW          = 8;
    localparam int          REG_DW          = 16;
    localparam logic [7:0]  ADDR_CLK_STATUS = 8'h0A;
    localparam logic [7:0]  ADDR_FAST_TRIM  = 8'h4D;
    localparam logic [7:0]  ADDR_ADC_CLOCK  = 8'h4E;
    localparam logic [7:0]  ADDR_SYNC_PIN   = 8'h4F;
    localparam logic [7:0]  ADDR_PIN_CAL    = 8'h50;

    localparam logic [15:0] RST_FAST_TRIM   = 16'h0098;
    localparam logic [15:0] RST_ADC_CLOCK   = 16'h0060;
    localparam logic [15:0] RST_SYNC_PIN    = 16'h2090;
    localparam logic [15:0] RST_PIN_CAL     = 16'h0000;
    localparam logic [15:0] ADC_CLOCK_1MHZ  = 16'h0040;
    localparam logic [15:0] ADC_CLOCK_500K  = 16'h0060;

    localparam int          TRIM_MSB        = 7;
    localparam int          PIN1_OE_BIT     = 6;
    localparam int          PIN1_IE_BIT     = 5;
    localparam int          SYNC_SEL_MSB    = 3;
    localparam int          SYNC_SEL_LSB    = 2;
    localparam int          PIN0_IE_BIT     = 1;
    localparam int          PIN1_SRC_BIT    = 6;
    localparam int          CAL_START_BIT   = 5;
    localparam int          STAT_BUSY_BIT   = 15;

    localparam logic [1:0]  SYNC_INTERNAL   = 2'h0;
    localparam logic [1:0]  SYNC_PIN_ZERO   = 2'h1;
    localparam logic [1:0]  SYNC_PIN_ONE    = 2'h2;
    localparam logic [1:0]  SYNC_RESERVED   = 2'h3;

    localparam int          RATIO_W         = 12;
    localparam logic [11:0] RATIO_MAX       = 12'hFFF;
    localparam int          PERIOD_MULT_SH  = 2;
    localparam int          SAMPLE_CNT_W    = 18;
endpackage : ssc_pkg

// [hdl/ssc_in_sync.sv]
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to sys_clk_in
// Notes:   A change is taken only once stages two and three agree
`timescale 1ns/1ps
module ssc_in_sync (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    logic out_d;

    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule : ssc_in_sync

// [hdl/ssc_config_top.sv]
// Purpose: Timing and pin configuration registers with sample sync and clock calibration
// Assumes: Register port is decoded from the serial host interface, one word per access
// Notes:   Slow clock arrives as a sampled input; ratio counts sys_clk per slow period
// What this block does
// - Fast oscillator trim, eight bits, default 0x98
// - ADC clock register, 0x0040 or 0x0060, default 0x0060
// - Bit 6 enables pin one driver
// - Bit 5 enables pin one input
// - Bit 1 enables pin zero input
// - Select 00 times samples from slow clock
// - Select 01/10 triggers samples from pins
// - Pin one driven low or power-down
// - Raising start bit from 0 to 1 launches ratio calculation
`timescale 1ns/1ps
module ssc_config_top (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    input  wire logic [15:0] sample_period_setting_in,
    input  wire logic        slow_clk_in,
    input  wire logic        general_pin_zero_in,
    input  wire logic        general_pin_one_in,
    output logic             general_pin_one_out,
    output logic             general_pin_one_oe_n_out,
    input  wire logic        afe_power_down_in,
    output logic      [7:0]  fast_osc_trim_out,
    output logic      [15:0] adc_conversion_clock_select_out,
    output logic             pin_zero_input_enable_out,
    output logic             pin_one_input_enable_out,
    output logic      [1:0]  sample_sync_select_out,
    output logic             sample_start_out,
    output logic             cal_busy_out,
    output logic      [11:0] clock_ratio_out
);
    typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_EDGE, CAL_COUNT} ssc_cal_e;

    // Register file
    logic [15:0] trim_q, trim_d;
    logic [15:0] adc_q, adc_d;
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] ctl_q, ctl_d;

    always_comb begin
        trim_d = trim_q;
        adc_d  = adc_q;
        cfg_d  = cfg_q;
        ctl_d  = ctl_q;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ssc_pkg::ADDR_FAST_TRIM: trim_d = reg_wdata_in;
                ssc_pkg::ADDR_ADC_CLOCK: adc_d  = reg_wdata_in;
                ssc_pkg::ADDR_SYNC_PIN:  cfg_d  = reg_wdata_in;
                ssc_pkg::ADDR_PIN_CAL:   ctl_d  = reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            trim_q <= ssc_pkg::RST_FAST_TRIM;
            adc_q  <= ssc_pkg::RST_ADC_CLOCK;
            cfg_q  <= ssc_pkg::RST_SYNC_PIN;
            ctl_q  <= ssc_pkg::RST_PIN_CAL;
        end else begin
            trim_q <= trim_d;
            adc_q  <= adc_d;
            cfg_q  <= cfg_d;
            ctl_q  <= ctl_d;
        end
    end

    wire logic [1:0] sync_sel = cfg_q[ssc_pkg::SYNC_SEL_MSB:ssc_pkg::SYNC_SEL_LSB];

    assign fast_osc_trim_out               = trim_q[ssc_pkg::TRIM_MSB:0];
    assign adc_conversion_clock_select_out = adc_q;
    assign pin_zero_input_enable_out       = cfg_q[ssc_pkg::PIN0_IE_BIT];
    assign pin_one_input_enable_out        = cfg_q[ssc_pkg::PIN1_IE_BIT];
    assign sample_sync_select_out          = sync_sel;

    // Pin and slow clock inputs
    logic slow_s, pin0_s, pin1_s;

    ssc_in_sync u_sync_slow (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   (slow_clk_in),
        .sync_out   (slow_s)
    );
    ssc_in_sync u_sync_pin0 (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   (general_pin_zero_in),
        .sync_out   (pin0_s)
    );
    ssc_in_sync u_sync_pin1 (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   (general_pin_one_in),
        .sync_out   (pin1_s)
    );

    // Sample cycle timing
    logic                   slow_prev_q, pin0_prev_q, pin1_prev_q;
    logic [17:0]            samp_cnt_q, samp_cnt_d;
    logic                   start_q, start_d;
    logic                   slow_rise, pin0_rise, pin1_rise;
    logic [17:0]            samp_limit;

    assign slow_rise  = slow_s & ~slow_prev_q;
    // Gated by input enable: a disabled buffer never triggers
    assign pin0_rise  = pin0_s & ~pin0_prev_q & cfg_q[ssc_pkg::PIN0_IE_BIT];
    assign pin1_rise  = pin1_s & ~pin1_prev_q & cfg_q[ssc_pkg::PIN1_IE_BIT];
    assign samp_limit = {sample_period_setting_in, 2'b00};

    always_comb begin
        samp_cnt_d = samp_cnt_q;
        start_d    = 1'b0;
        unique case (sync_sel)
            ssc_pkg::SYNC_INTERNAL: begin
                // Zero period setting parks the sampler
                if (slow_rise && samp_limit != 18'h0_0000) begin
                    if (samp_cnt_q + 18'h0_0001 >= samp_limit) begin
                        samp_cnt_d = 18'h0_0000;
                        start_d    = 1'b1;
                    end else begin
                        samp_cnt_d = samp_cnt_q + 18'h0_0001;
                    end
                end
            end
            ssc_pkg::SYNC_PIN_ZERO: begin
                samp_cnt_d = 18'h0_0000;
                start_d    = pin0_rise;
            end
            ssc_pkg::SYNC_PIN_ONE: begin
                samp_cnt_d = 18'h0_0000;
                start_d    = pin1_rise;
            end
            ssc_pkg::SYNC_RESERVED: begin
                samp_cnt_d = 18'h0_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            slow_prev_q <= 1'b0;
            pin0_prev_q <= 1'b0;
            pin1_prev_q <= 1'b0;
            samp_cnt_q  <= 18'h0_0000;
            start_q     <= 1'b0;
        end else begin
            slow_prev_q <= slow_s;
            pin0_prev_q <= pin0_s;
            pin1_prev_q <= pin1_s;
            samp_cnt_q  <= samp_cnt_d;
            start_q     <= start_d;
        end
    end

    assign sample_start_out = start_q;

    // Clock ratio calibration
    ssc_cal_e    cal_st_q, cal_st_d;
    logic        cal_prev_q;
    logic [11:0] cal_cnt_q, cal_cnt_d;
    logic [11:0] ratio_q, ratio_d;
    logic        cal_launch;

    // Launch only on a 0 to 1 of the start bit, so host must clear first
    assign cal_launch = ctl_q[ssc_pkg::CAL_START_BIT] & ~cal_prev_q;

    always_comb begin
        cal_st_d  = cal_st_q;
        cal_cnt_d = cal_cnt_q;
        ratio_d   = ratio_q;
        unique case (cal_st_q)
            CAL_IDLE: begin
                if (cal_launch) begin
                    cal_st_d = CAL_WAIT_EDGE;
                end
            end
            CAL_WAIT_EDGE: begin
                cal_cnt_d = 12'h000;
                if (slow_rise) begin
                    cal_st_d = CAL_COUNT;
                end
            end
            CAL_COUNT: begin
                if (slow_rise) begin
                    // Lost slow edge: hold the ceiling rather than wrap to zero
                    ratio_d  = (cal_cnt_q == ssc_pkg::RATIO_MAX) ? cal_cnt_q
                                                                 : cal_cnt_q + 12'h001;
                    cal_st_d = CAL_IDLE;
                end else if (cal_cnt_q != ssc_pkg::RATIO_MAX) begin
                    cal_cnt_d = cal_cnt_q + 12'h001;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cal_st_q   <= CAL_IDLE;
            cal_prev_q <= 1'b0;
            cal_cnt_q  <= 12'h000;
            ratio_q    <= 12'h000;
        end else begin
            cal_st_q   <= cal_st_d;
            cal_prev_q <= ctl_q[ssc_pkg::CAL_START_BIT];
            cal_cnt_q  <= cal_cnt_d;
            ratio_q    <= ratio_d;
        end
    end

    logic busy_q;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (cal_st_d != CAL_IDLE);
        end
    end
    assign cal_busy_out    = busy_q;
    assign clock_ratio_out = ratio_q;

    // Pin one driver and register reads
    logic        p1_out_q, p1_out_d, p1_oen_q, p1_oen_d;
    logic [15:0] rdata_q, rdata_d;
    logic        rvalid_q;

    always_comb begin
        // Source 0 holds the pin low, 1 passes the power-down level
        p1_out_d = ctl_q[ssc_pkg::PIN1_SRC_BIT] & afe_power_down_in;
        p1_oen_d = ~cfg_q[ssc_pkg::PIN1_OE_BIT];
        rdata_d  = 16'h0000;
        unique case (reg_addr_in)
            ssc_pkg::ADDR_CLK_STATUS: begin
                rdata_d = {busy_q, 3'h0, ratio_q};
            end
            ssc_pkg::ADDR_FAST_TRIM: rdata_d = trim_q;
            ssc_pkg::ADDR_ADC_CLOCK: rdata_d = adc_q;
            ssc_pkg::ADDR_SYNC_PIN:  rdata_d = cfg_q;
            ssc_pkg::ADDR_PIN_CAL:   rdata_d = ctl_q;
            default:                 rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            p1_out_q <= 1'b0;
            p1_oen_q <= 1'b1;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            p1_out_q <= p1_out_d;
            p1_oen_q <= p1_oen_d;
            rdata_q  <= reg_rd_in ? rdata_d : rdata_q;
            rvalid_q <= reg_rd_in;
        end
    end

    assign general_pin_one_out      = p1_out_q;
    assign general_pin_one_oe_n_out = p1_oen_q;
    assign reg_rdata_out            = rdata_q;
    assign reg_rvalid_out           = rvalid_q;

    // Checks
    sequence s_trim_write;
        reg_wr_in && reg_addr_in == ssc_pkg::ADDR_FAST_TRIM;
    endsequence
    sequence s_pin0_trigger;
        sync_sel == ssc_pkg::SYNC_PIN_ZERO && pin0_rise;
    endsequence
    sequence s_pin1_trigger;
        sync_sel == ssc_pkg::SYNC_PIN_ONE && pin1_rise;
    endsequence
    sequence s_cal_launch;
        cal_st_q == CAL_IDLE && cal_launch;
    endsequence

    a_trim_reset_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $fell(rst_in) |-> fast_osc_trim_out == 8'h98 && adc_conversion_clock_select_out == 16'h0060)
        else $error("trim or adc clock reset value wrong");
    a_trim_write_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_trim_write |=> fast_osc_trim_out == $past(reg_wdata_in[7:0]))
        else $error("trim write not taken");
    a_adc_write_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == ssc_pkg::ADDR_ADC_CLOCK
        |=> adc_conversion_clock_select_out == $past(reg_wdata_in))
        else $error("adc clock write not taken");
    a_pin1_driver_enable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == ssc_pkg::ADDR_SYNC_PIN
        |=> ##1 general_pin_one_oe_n_out == !$past(reg_wdata_in[6], 2))
        else $error("pin one driver enable mismatch");
    a_pin1_input_enable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == ssc_pkg::ADDR_SYNC_PIN
        |=> pin_one_input_enable_out == $past(reg_wdata_in[5]))
        else $error("pin one input enable mismatch");
    a_pin0_input_enable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == ssc_pkg::ADDR_SYNC_PIN
        |=> pin_zero_input_enable_out == $past(reg_wdata_in[1]))
        else $error("pin zero input enable mismatch");
    a_internal_sync_cause: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sample_start_out && $past(sync_sel) == ssc_pkg::SYNC_INTERNAL |-> $past(slow_rise))
        else $error("internal sample start without slow clock edge");
    a_reserved_sync_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sync_sel == ssc_pkg::SYNC_RESERVED |=> !sample_start_out)
        else $error("sample start in reserved sync mode");
    a_pin_trigger_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_pin0_trigger or s_pin1_trigger |=> sample_start_out)
        else $error("pin trigger did not start a sample");
    a_pin1_output_source: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> general_pin_one_out == ($past(ctl_q[6]) && $past(afe_power_down_in)))
        else $error("pin one output source wrong");
    a_cal_launch_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_cal_launch |=> cal_busy_out ##0 (cal_st_q == CAL_WAIT_EDGE))
        else $error("calibration did not launch");
endmodule : ssc_config_top

// [verif/ssc_host_model.sv]
// Purpose: Host side of the register port, one word per access
// Assumes: Requests change on the falling edge, held over the taking rising edge
// Notes:   Task-driven; the bench calls the tasks through the instance
`timescale 1ns/1ps
module ssc_host_model (
    input  wire logic        sys_clk_in,
    output logic      [7:0]  reg_addr_out,
    output logic      [15:0] reg_wdata_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        reg_rvalid_in
);
    initial begin
        reg_addr_out  = 8'h00;
        reg_wdata_out = 16'h0000;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end

    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_out    = 1'b0;
        // Stale data would hide a late sample
        reg_wdata_out = ~d;
    endtask : write_word

    task automatic read_word(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge sys_clk_in);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_out   = 1'b0;
        d            = reg_rdata_in;
        v            = reg_rvalid_in;
    endtask : read_word

    // Fixed reserved values kept on every write of the pin register
    task automatic set_pins(input logic [15:0] fields);
        logic [1:0] sel;
        sel = fields[3:2];
        write_word(8'h38, (sel == 2'h1 || sel == 2'h2) ? 16'h4000 : 16'h0000);
        write_word(ssc_pkg::ADDR_SYNC_PIN, 16'h2090 | fields);
    endtask : set_pins

    // Start bit cleared first so every launch is a fresh rising bit
    task automatic launch_cal(input logic [15:0] src);
        write_word(ssc_pkg::ADDR_PIN_CAL, src);
        write_word(ssc_pkg::ADDR_PIN_CAL, src | 16'h0020);
    endtask : launch_cal
endmodule : ssc_host_model

// [verif/ssc_config_top_tb.sv]
// Purpose: Self-checking bench for the configuration block
// Assumes: Slow clock of 32 system cycles, made on falling edges
// Notes:   Reset values and register rows first, then triggers, calibration and a second reset
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t ns: got %h expected %h", $time, (g), (e)); end end
module ssc_config_top_tb;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} ssc_row_s;
    logic sys_clk_in, rst_in, reg_wr, reg_rd, rvalid, slow_clk, pin0, pin1, afe_pd;
    logic pin1_out, pin1_oe_n, ie0, ie1, start, busy;
    logic [7:0]  reg_addr, trim;
    logic [15:0] reg_wdata, rdata, setting, adc_sel;
    logic [1:0]  sync_sel;
    logic [11:0] ratio;
    int          errors = 0;
    int          cmp_count = 0;
    ssc_row_s    rows [8];

    ssc_config_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sample_period_setting_in(setting),
        .slow_clk_in(slow_clk), .general_pin_zero_in(pin0), .general_pin_one_in(pin1),
        .general_pin_one_out(pin1_out), .general_pin_one_oe_n_out(pin1_oe_n),
        .afe_power_down_in(afe_pd), .fast_osc_trim_out(trim),
        .adc_conversion_clock_select_out(adc_sel), .pin_zero_input_enable_out(ie0),
        .pin_one_input_enable_out(ie1), .sample_sync_select_out(sync_sel),
        .sample_start_out(start), .cal_busy_out(busy), .clock_ratio_out(ratio));
    ssc_host_model host_u (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        slow_clk = 1'b0;
        forever begin
            repeat (16) @(negedge sys_clk_in);
            slow_clk = ~slow_clk;
        end
    end

    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check_read(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        host_u.read_word(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask : check_read

    task automatic do_reset(input int n);
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        repeat (n) @(negedge sys_clk_in);
        rst_in = 1'b0;
    endtask : do_reset

    task automatic check_reset;
        check_read(ssc_pkg::ADDR_FAST_TRIM, 16'h0098);
        check_read(ssc_pkg::ADDR_ADC_CLOCK, 16'h0060);
        check_read(ssc_pkg::ADDR_SYNC_PIN, 16'h2090);
        check_read(ssc_pkg::ADDR_PIN_CAL, 16'h0000);
        `CHK(trim, 8'h98)
        `CHK(pin1_oe_n, 1'b1)
        `CHK(ie1, 1'b0)
        `CHK(ie0, 1'b0)
        `CHK(sync_sel, 2'h0)
        `CHK(pin1_out, 1'b0)
        `CHK(busy, 1'b0)
        `CHK(ratio, 12'h000)
    endtask : check_reset

    task automatic count_starts(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge sys_clk_in);
            // An unknown start counts, so it cannot pass a zero expectation
            if (start !== 1'b0) n++;
        end
    endtask : count_starts

    task automatic trig(input logic [15:0] f, input logic p0, input logic p1, input int e);
        int n1;
        int n2;
        host_u.set_pins(f);
        pin0 = p0;
        pin1 = p1;
        count_starts(20, n1);
        pin0 = 1'b0;
        pin1 = 1'b0;
        count_starts(20, n2);
        `CHK(n1 + n2, e)
    endtask : trig

    initial begin
        #(20000 * 100);
        errors++;
        end_of_test();
    end

    initial begin
        int k;
        int n;
        rst_in  = 1'b1;
        setting = 16'h0001;
        pin0    = 1'b0;
        pin1    = 1'b0;
        afe_pd  = 1'b1;
        rows = '{'{8'h4D, 16'h0000, 16'h0000}, '{8'h4D, 16'h00FF, 16'h00FF},
                 '{8'h4E, 16'h0040, 16'h0040}, '{8'h4E, 16'h0060, 16'h0060},
                 '{8'h4F, 16'h20D0, 16'h20D0}, '{8'h50, 16'h0040, 16'h0040},
                 '{8'h0A, 16'hFFFF, 16'h0000}, '{8'h33, 16'hABCD, 16'h0000}};
        repeat (10) @(negedge sys_clk_in);
        rst_in = 1'b0;
        check_reset();
        foreach (rows[i]) begin
            host_u.write_word(rows[i].a, rows[i].d);
            check_read(rows[i].a, rows[i].e);
        end
        `CHK(trim, 8'hFF)
        `CHK(adc_sel, 16'h0060)
        `CHK(pin1_oe_n, 1'b0)
        `CHK(pin1_out, 1'b1)
        afe_pd = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        `CHK(pin1_out, 1'b0)
        // Slow clock timing: four slow periods of 32 cycles per start
        host_u.set_pins(16'h0000);
        for (k = 0; k < 400 && start !== 1'b1; k++) @(negedge sys_clk_in);
        for (n = 1, k = 0; k < 400 && n < 200; n++) begin
            @(negedge sys_clk_in);
            if (start === 1'b1) k = 400;
        end
        `CHK(n, 129)
        trig(16'h0006, 1'b1, 1'b0, 1);
        trig(16'h0028, 1'b0, 1'b1, 1);
        trig(16'h0028, 1'b1, 1'b0, 0);
        trig(16'h0004, 1'b1, 1'b0, 0);
        trig(16'h0008, 1'b0, 1'b1, 0);
        trig(16'h002E, 1'b1, 1'b1, 0);
        host_u.write_word(8'h5F, 16'h0001);
        host_u.launch_cal(16'h0000);
        for (k = 0; k < 50 && busy !== 1'b1; k++) @(negedge sys_clk_in);
        `CHK(busy, 1'b1)
        for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge sys_clk_in);
        `CHK(busy, 1'b0)
        `CHK(ratio, 12'h020)
        check_read(ssc_pkg::ADDR_CLK_STATUS, 16'h0020);
        host_u.write_word(8'h5F, 16'h0000);
        // Bit left high: rewriting it must not relaunch
        host_u.write_word(ssc_pkg::ADDR_PIN_CAL, 16'h0020);
        repeat (5) @(negedge sys_clk_in);
        `CHK(busy, 1'b0)
        host_u.write_word(8'h5F, 16'h0001);
        host_u.launch_cal(16'h0000);
        for (k = 0; k < 50 && busy !== 1'b1; k++) @(negedge sys_clk_in);
        `CHK(busy, 1'b1)
        do_reset(2);
        check_reset();
        end_of_test();
    end
endmodule : ssc_config_top_tb
